// *** inc/rftx_pkg.sv ***
// Shared constants and carrier types for the radio transmit encoder.
// Assumes one 100 MHz clock domain and an APB master on the register side.
//
// How it works
// - Transmitter runs only while tx enable is 1 and rx enable is 0.
// - Symbol rate equals clock divided by 16 times fine times coarse.
// - Coarse 00 with fine 0000 gives product 1, rate clock/16.
// - Coarse 01 with fine 0010 gives product 12; coarse step is x4.
// - External clock select 0 means bits are timed by internal baud generator.
// - Encoder on with coding 010 applies NRZ space encoding.
// - Encoder on with coding 111 applies Miller encoding.
// - NRZ space turns an all-zero byte into line pattern 10101010 from the idle low line.
// - Transmit FIFO holds four bytes; full after four writes.
// - Transmit interrupt flags that the FIFO has become empty.
// - Empty flag rises when last byte enters shifter, before it leaves.
// - Encoder off sends raw bits, allowing deliberate coding violations.
// - Encoder settings are taken only when a byte loads into the shifter.
// - Miller sends two line symbols per data bit.
// - Pin 3 carries transmit data; pins 0 to 2 unused when sending.
package rftx_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BAUD = 8'h04;
    localparam logic [7:0] OFS_TX_DATA = 8'h08;
    localparam logic [7:0] OFS_STATE = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;

    // line coding select values
    localparam logic [2:0] CODE_NRZ_LEVEL = 3'h0;
    localparam logic [2:0] CODE_NRZ_MARK = 3'h1;
    localparam logic [2:0] CODE_NRZ_SPACE = 3'h2;
    localparam logic [2:0] CODE_MANCH_LEVEL = 3'h3;
    localparam logic [2:0] CODE_MILLER = 3'h7;

    // baud generator: 16x prescale, coarse steps of x4 (shift by two)
    localparam logic [3:0] BAUD_PRESCALE_SHIFT = 4'h4;
    localparam int BAUD_CNT_W = 15;

    // fifo and byte shape
    localparam int FIFO_DEPTH = 4;
    localparam logic [2:0] FIFO_FULL_COUNT = 3'h4;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // interrupt status bit positions
    localparam int IRQ_W = 2;
    localparam int IRQ_FIFO_EMPTY = 0;
    localparam int IRQ_OVERFLOW = 1;

    // reset values
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [5:0] BAUD_RESET = 6'h00;
    localparam logic IDLE_LEVEL = 1'b0;
    localparam logic MILLER_PREV_RESET = 1'b1;

    // control register: bit 0 rx en, 1 tx en, 2 enc en, 5:3 coding, 6 ext clk
    typedef struct packed {
        logic tx_external_clock_select;
        logic [2:0] line_coding_select;
        logic encoder_enable_bit;
        logic tx_enable_bit;
        logic rx_enable_bit;
    } ctrl_s;

    // baud register: bits 3:0 fine, 5:4 coarse
    typedef struct packed {
        logic [1:0] baud_coarse_field;
        logic [3:0] baud_fine_field;
    } baud_s;

    // encoder setting frozen per byte
    typedef struct packed {
        logic enc_en;
        logic [2:0] coding;
    } mode_s;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SHIFT = 1'b1
    } tx_state_e;

endpackage : rftx_pkg

// *** verilog/radio_tx_encoder_fifo.sv ***
// Transmit path of the radio serial interface: APB registers, four-byte
// FIFO, baud generator, shift register and line encoder.
// Assumes APB master on CLOCK_I; the bit clock pin is asynchronous.
//
// Added by the designer: the APB interface to the registers and the register addresses.
module radio_tx_encoder_fifo (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // radio pins
    input wire logic RADIO_PIN_BIT_CLOCK_I,
    output logic RADIO_PIN_TX_DATA_O,
    output logic RADIO_PIN_TX_DATA_OE_O,
    // interrupt
    output logic IRQ_O
);

    rftx_pkg::ctrl_s ctrl_r;
    rftx_pkg::baud_s baud_r;
    rftx_pkg::mode_s mode_r;
    rftx_pkg::tx_state_e state_r;
    logic [rftx_pkg::IRQ_W-1:0] irq_status_r;
    logic [rftx_pkg::IRQ_W-1:0] irq_status_nxt;
    logic [rftx_pkg::IRQ_W-1:0] irq_enable_r;
    logic [31:0] prdata_r;
    logic [7:0] fifo_mem_r [rftx_pkg::FIFO_DEPTH];
    logic [1:0] wr_ptr_r;
    logic [1:0] rd_ptr_r;
    logic [2:0] count_r;
    logic [rftx_pkg::BAUD_CNT_W-1:0] div_cnt_r;
    logic [rftx_pkg::BAUD_CNT_W-1:0] period;
    logic [4:0] fine_p1;
    logic [3:0] shamt;
    logic bclk_meta_r;
    logic bclk_sync_r;
    logic bclk_prev_r;
    logic bclk_rise;
    logic [7:0] byte_r;
    logic [2:0] bit_cnt_r;
    logic half_r;
    logic prev_bit_r;
    logic level_r;
    logic level_nxt;
    logic two_sym;
    logic last_sym;
    logic tx_active;
    logic tick;
    logic emit;
    logic load;
    logic fifo_empty;
    logic fifo_full;
    logic setup;
    logic access;
    logic wr_en;
    logic addr_ok;
    logic push;
    logic overflow;

    // apb decode; zero-wait slave, every access finishes in its first access cycle
    assign setup = PSEL_I && !PENABLE_I;
    assign access = PSEL_I && PENABLE_I;
    assign wr_en = access && PWRITE_I && addr_ok;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = access && !addr_ok;
    assign PRDATA_O = prdata_r;

    always_comb begin
        unique case (PADDR_I)
            rftx_pkg::OFS_CTRL, rftx_pkg::OFS_BAUD, rftx_pkg::OFS_TX_DATA,
            rftx_pkg::OFS_STATE, rftx_pkg::OFS_IRQ_STATUS,
            rftx_pkg::OFS_IRQ_CLEAR, rftx_pkg::OFS_IRQ_ENABLE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            prdata_r <= 32'h0;
        end else if (setup && !PWRITE_I) begin
            unique case (PADDR_I)
                rftx_pkg::OFS_CTRL: prdata_r <= {25'h0, ctrl_r};
                rftx_pkg::OFS_BAUD: prdata_r <= {26'h0, baud_r};
                rftx_pkg::OFS_STATE: begin
                    prdata_r <= {25'h0, tx_active, level_r, state_r, fifo_full, count_r};
                end
                rftx_pkg::OFS_IRQ_STATUS: prdata_r <= {30'h0, irq_status_r};
                rftx_pkg::OFS_IRQ_ENABLE: prdata_r <= {30'h0, irq_enable_r};
                default: prdata_r <= 32'h0; // write-only and unmapped read zero
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            ctrl_r <= rftx_pkg::ctrl_s'(rftx_pkg::CTRL_RESET);
            baud_r <= rftx_pkg::baud_s'(rftx_pkg::BAUD_RESET);
            irq_enable_r <= '0;
        end else if (wr_en) begin
            if (PADDR_I == rftx_pkg::OFS_CTRL) begin
                ctrl_r <= rftx_pkg::ctrl_s'(PWDATA_I[6:0]);
            end
            if (PADDR_I == rftx_pkg::OFS_BAUD) begin
                baud_r <= rftx_pkg::baud_s'(PWDATA_I[5:0]);
            end
            if (PADDR_I == rftx_pkg::OFS_IRQ_ENABLE) begin
                irq_enable_r <= PWDATA_I[rftx_pkg::IRQ_W-1:0];
            end
        end
    end

    // fifo; a write to a full fifo is dropped and flagged unless a byte loads in the same cycle
    assign push = wr_en && (PADDR_I == rftx_pkg::OFS_TX_DATA);
    assign overflow = push && fifo_full && !load;
    assign fifo_empty = (count_r == 3'h0);
    assign fifo_full = (count_r == rftx_pkg::FIFO_FULL_COUNT);

    // pointers wrap at depth four; the count tells full from empty
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            wr_ptr_r <= 2'h0;
            rd_ptr_r <= 2'h0;
            count_r <= 3'h0;
        end else begin
            if (push && !overflow) begin
                fifo_mem_r[wr_ptr_r] <= PWDATA_I[7:0];
                wr_ptr_r <= wr_ptr_r + 2'h1;
            end
            if (load) begin
                rd_ptr_r <= rd_ptr_r + 2'h1;
            end
            count_r <= count_r + 3'((push && !overflow) ? 1 : 0) - 3'(load ? 1 : 0);
        end
    end

    // bit clock pin synchroniser; edge detect reads only the second and third stages
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            bclk_meta_r <= 1'b0;
            bclk_sync_r <= 1'b0;
            bclk_prev_r <= 1'b0;
        end else begin
            bclk_meta_r <= RADIO_PIN_BIT_CLOCK_I;
            bclk_sync_r <= bclk_meta_r;
            bclk_prev_r <= bclk_sync_r;
        end
    end
    assign bclk_rise = bclk_sync_r && !bclk_prev_r;

    // symbol period = 16 * (fine+1) * 4^coarse clocks
    assign fine_p1 = {1'b0, baud_r.baud_fine_field} + 5'h01;
    assign shamt = rftx_pkg::BAUD_PRESCALE_SHIFT + {1'b0, baud_r.baud_coarse_field, 1'b0};
    assign period = rftx_pkg::BAUD_CNT_W'({10'h0, fine_p1} << shamt);

    // free-running divider; wraps early if the period shrinks under it
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            div_cnt_r <= '0;
        end else if (div_cnt_r >= period - 15'h1) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + 15'h1;
        end
    end

    assign tx_active = ctrl_r.tx_enable_bit && !ctrl_r.rx_enable_bit;
    // external pin edges replace the internal divider only when selected
    assign tick = tx_active && (ctrl_r.tx_external_clock_select ? bclk_rise
                                : (div_cnt_r == period - 15'h1));
    // ticks while idle pass unused; the divider keeps its phase
    assign emit = tick && (state_r == rftx_pkg::TX_SHIFT);

    // two-symbol codes send half bits, so the baud must be twice the bit rate
    assign two_sym = mode_r.enc_en && (mode_r.coding == rftx_pkg::CODE_MILLER ||
                                       mode_r.coding == rftx_pkg::CODE_MANCH_LEVEL);
    assign last_sym = (bit_cnt_r == rftx_pkg::LAST_BIT) && (!two_sym || half_r);
    // idle loads at once; a running byte chains the next on its last symbol
    assign load = !fifo_empty && tx_active &&
                  ((state_r == rftx_pkg::TX_IDLE) || (emit && last_sym));

    // line level for the symbol being sent, msb first
    always_comb begin
        level_nxt = level_r;
        if (!mode_r.enc_en) begin
            level_nxt = byte_r[7];
        end else begin
            unique case (mode_r.coding)
                rftx_pkg::CODE_NRZ_MARK: level_nxt = level_r ^ byte_r[7];
                rftx_pkg::CODE_NRZ_SPACE: level_nxt = level_r ^ !byte_r[7];
                rftx_pkg::CODE_MANCH_LEVEL: level_nxt = byte_r[7] ^ half_r;
                rftx_pkg::CODE_MILLER: begin
                    // mid-bit toggle for 1, boundary toggle between two 0s
                    level_nxt = half_r ? (level_r ^ byte_r[7])
                                       : (level_r ^ (!byte_r[7] && !prev_bit_r));
                end
                default: level_nxt = byte_r[7];
            endcase
        end
    end

    // shifter and encoder state
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            state_r <= rftx_pkg::TX_IDLE;
            byte_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            half_r <= 1'b0;
            prev_bit_r <= rftx_pkg::MILLER_PREV_RESET;
            level_r <= rftx_pkg::IDLE_LEVEL;
            mode_r <= '0;
        end else begin
            if (emit) begin
                level_r <= level_nxt;
                if (!two_sym || half_r) begin
                    byte_r <= {byte_r[6:0], 1'b0};
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                    prev_bit_r <= byte_r[7];
                    half_r <= 1'b0;
                end else begin
                    half_r <= 1'b1;
                end
                if (last_sym && !load) begin
                    state_r <= rftx_pkg::TX_IDLE; // level_r simply holds
                end
            end
            if (load) begin
                state_r <= rftx_pkg::TX_SHIFT;
                byte_r <= fifo_mem_r[rd_ptr_r];
                bit_cnt_r <= 3'h0;
                half_r <= 1'b0;
                // settings sampled only here, never mid-byte
                mode_r <= '{enc_en: ctrl_r.encoder_enable_bit,
                            coding: ctrl_r.line_coding_select};
            end
        end
    end

    assign RADIO_PIN_TX_DATA_O = level_r;
    assign RADIO_PIN_TX_DATA_OE_O = tx_active;

    // sticky status; a set in the clear cycle wins
    always_comb begin
        irq_status_nxt = irq_status_r;
        if (wr_en && PADDR_I == rftx_pkg::OFS_IRQ_CLEAR) begin
            irq_status_nxt = irq_status_nxt & ~PWDATA_I[rftx_pkg::IRQ_W-1:0];
        end
        // the last byte leaving the fifo raises the empty event at once
        if (load && count_r == 3'h1 && !push) begin
            irq_status_nxt[rftx_pkg::IRQ_FIFO_EMPTY] = 1'b1;
        end
        if (overflow) begin
            irq_status_nxt[rftx_pkg::IRQ_OVERFLOW] = 1'b1;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            irq_status_r <= '0;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    assign IRQ_O = |(irq_status_r & irq_enable_r);

    // helper: clocks since the last tick, valid once baud has been steady
    logic [rftx_pkg::BAUD_CNT_W-1:0] gap_cnt_r;
    logic gap_ok_r;
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            gap_cnt_r <= '0;
            gap_ok_r <= 1'b0;
        end else begin
            gap_cnt_r <= tick ? '0 : gap_cnt_r + 15'h1;
            if (!tx_active || ctrl_r.tx_external_clock_select ||
                (wr_en && PADDR_I == rftx_pkg::OFS_BAUD)) begin
                gap_ok_r <= 1'b0;
            end else if (tick) begin
                gap_ok_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);

    chk_inactive_no_load: assert property (!tx_active |-> !load && !tick)
        else $error("shifter moved while transmitter not enabled");
    chk_baud_gap_period: assert property (tick && gap_ok_r |-> gap_cnt_r == period - 15'h1)
        else $error("symbol tick spacing differs from baud period");
    chk_baud_unity: assert property (baud_r == 6'h00 |-> period == 15'h0010)
        else $error("coarse 00 fine 0000 period is not 16 clocks");
    chk_baud_twelve: assert property (baud_r == 6'h12 |-> period == 15'h00C0)
        else $error("coarse 01 fine 0010 period is not 192 clocks");
    chk_internal_timing: assert property (
        !ctrl_r.tx_external_clock_select && div_cnt_r != period - 15'h1 |-> !tick)
        else $error("tick without internal divider wrap");

    // encoder line checks
    chk_nrzs_zero_toggle: assert property (
        emit && mode_r.enc_en && mode_r.coding == rftx_pkg::CODE_NRZ_SPACE && !byte_r[7]
        |=> level_r != $past(level_r))
        else $error("nrz space zero bit did not toggle line");
    chk_nrzs_one_hold: assert property (
        emit && mode_r.enc_en && mode_r.coding == rftx_pkg::CODE_NRZ_SPACE && byte_r[7]
        |=> $stable(level_r))
        else $error("nrz space one bit changed line");
    chk_miller_mid_toggle: assert property (
        emit && two_sym && mode_r.coding == rftx_pkg::CODE_MILLER && half_r && byte_r[7]
        |=> level_r != $past(level_r))
        else $error("miller one bit lacks mid-bit transition");
    chk_miller_zero_pair: assert property (
        emit && two_sym && mode_r.coding == rftx_pkg::CODE_MILLER && !half_r
        && !byte_r[7] && !prev_bit_r |=> level_r != $past(level_r))
        else $error("miller zero pair lacks boundary transition");
    chk_miller_zero_mid: assert property (
        emit && two_sym && mode_r.coding == rftx_pkg::CODE_MILLER && half_r && !byte_r[7]
        |=> $stable(level_r))
        else $error("miller zero bit toggled mid-bit");
    chk_miller_two_sym: assert property (
        emit && two_sym && !half_r |=> half_r && $stable(bit_cnt_r))
        else $error("two-symbol code advanced bit after one symbol");
    // the line may only move on a symbol tick
    chk_line_on_tick: assert property (!emit |=> $stable(level_r))
        else $error("line changed between symbol ticks");

    // fifo and interrupt checks
    chk_fifo_fills_four: assert property (
        push && count_r == 3'h3 && !load |=> fifo_full ##1 !fifo_empty)
        else $error("fifo not full after fourth byte");
    chk_count_bound: assert property (count_r <= rftx_pkg::FIFO_FULL_COUNT)
        else $error("fifo count above depth");
    chk_overflow_flag: assert property (overflow |=> fifo_full && irq_status_r[rftx_pkg::IRQ_OVERFLOW])
        else $error("overflowing write not flagged or not dropped");
    chk_empty_event: assert property (
        load && count_r == 3'h1 && !push |=> irq_status_r[rftx_pkg::IRQ_FIFO_EMPTY]
        && state_r == rftx_pkg::TX_SHIFT)
        else $error("empty event missing while last byte shifts");
    // a clear in the very cycle of the empty event must not lose it
    chk_set_beats_clear: assert property (
        load && count_r == 3'h1 && wr_en && PADDR_I == rftx_pkg::OFS_IRQ_CLEAR
        |=> irq_status_r[rftx_pkg::IRQ_FIFO_EMPTY])
        else $error("fifo empty event lost to a clear");
    chk_raw_bit: assert property (emit && !mode_r.enc_en |=> level_r == $past(byte_r[7]))
        else $error("raw mode line differs from data bit");
    chk_load_takes_mode: assert property (
        load |=> mode_r.enc_en == $past(ctrl_r.encoder_enable_bit))
        else $error("byte did not take the current encoder setting");
    chk_mode_frozen: assert property (
        state_r == rftx_pkg::TX_SHIFT && !load |=> $stable(mode_r))
        else $error("encoder mode changed during a byte");
    chk_idle_hold: assert property (state_r == rftx_pkg::TX_IDLE |=> $stable(level_r))
        else $error("line moved while idle");
    chk_no_gap: assert property (
        emit && last_sym && !fifo_empty |=> state_r == rftx_pkg::TX_SHIFT && bit_cnt_r == 3'h0)
        else $error("gap between chained bytes");
    chk_pop_order: assert property (
        load |=> byte_r == $past(fifo_mem_r[rd_ptr_r]))
        else $error("shifter loaded a byte out of order");

    // cover points for the main scenarios
    cov_chain_bytes: cover property (emit && last_sym && load);
    cov_miller_byte: cover property (load ##1 mode_r.coding == rftx_pkg::CODE_MILLER);
    cov_irq_raise: cover property (!IRQ_O ##1 IRQ_O);
    cov_overflow: cover property (overflow);
    cov_ext_clock: cover property (emit && ctrl_r.tx_external_clock_select);

endmodule : radio_tx_encoder_fifo

// *** sim/rf_txd_sink.sv ***
// Far-side model: transceiver transmit data input plus its bit clock pin.
// Assumes the bench arms it with the symbol period before a message starts.
module rf_txd_sink (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // radio pins
    input wire logic txd_i,
    output logic bit_clk_o,
    // bench control
    input wire logic arm_i,
    input wire logic clk_run_i,
    input wire logic [31:0] period_i,
    output logic [63:0] sym_o,
    output int count_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic last_r;
    logic locked_r;
    int tmr_r;
    logic [1:0] div_r;

    initial bit_clk_o = 1'b0;

    // bit clock runs only when told, stands still otherwise
    always @(posedge clk_i) begin
        if (rst_i || !clk_run_i) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
        bit_clk_o <= div_r[1];
    end

    // mid-symbol sampler locked on the first line change after arming
    always @(posedge clk_i) begin
        if (rst_i || !arm_i) begin
            locked_r <= 1'b0;
            count_o <= 0;
            tmr_r <= 0;
            last_r <= txd_i;
        end else if (!locked_r) begin
            if (txd_i !== last_r) begin
                locked_r <= 1'b1;
                tmr_r <= period_i / 2;
            end
        end else if (tmr_r <= 1) begin
            if (count_o < 64) begin
                sym_o[count_o] <= txd_i;
            end
            count_o <= count_o + 1;
            tmr_r <= period_i; // drift shows up as a wrong symbol later
        end else begin
            tmr_r <= tmr_r - 1;
        end
    end
endmodule : rf_txd_sink

// *** sim/radio_tx_encoder_fifo_tb.sv ***
// Self-checking bench for the radio transmit encoder with its FIFO.
// Assumes zero-wait APB and a free-running baud divider of unknown phase.
module radio_tx_encoder_fifo_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst, psel, penable, pwrite, pready, pslverr, txd, oe, irq, bclk;
    logic arm, clk_run, prv, lvl, err;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] seed;
    logic [63:0] sym;
    logic exp_q[$];
    int per, cnt, fails, checked, i;

    radio_tx_encoder_fifo i_dut (.CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .RADIO_PIN_BIT_CLOCK_I(bclk), .RADIO_PIN_TX_DATA_O(txd),
        .RADIO_PIN_TX_DATA_OE_O(oe), .IRQ_O(irq));

    rf_txd_sink i_sink (.clk_i(clk), .rst_i(rst), .txd_i(txd), .bit_clk_o(bclk),
        .arm_i(arm), .clk_run_i(clk_run), .period_i(per), .sym_o(sym), .count_o(cnt));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task end_sim;
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task chk(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // symbol period in clocks from coarse and fine fields
    function int sym_period(input int c, input int f);
        return (16 * (f + 1)) << (2 * c);
    endfunction : sym_period

    // expected line symbols, msb first
    task enc_byte(input logic [7:0] v, input logic en, input logic [2:0] code);
        for (int k = 7; k >= 0; k--) begin
            if (!en) begin
                lvl = v[k];
            end else if (code == rftx_pkg::CODE_NRZ_SPACE) begin
                lvl = v[k] ? lvl : ~lvl;
            end else begin
                lvl = (!v[k] && !prv) ? ~lvl : lvl;
                exp_q.push_back(lvl);
                lvl = v[k] ? ~lvl : lvl;
                prv = v[k];
            end
            exp_q.push_back(lvl);
        end
    endtask : enc_byte

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a stuck access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task do_reset;
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        exp_q.delete();
        lvl = rftx_pkg::IDLE_LEVEL;
        prv = rftx_pkg::MILLER_PREV_RESET;
    endtask : do_reset

    task start_cap(input int p);
        @(posedge clk);
        per <= p;
        arm <= 1'b1;
    endtask : start_cap

    task wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        #1 chk(irq, 1);
    endtask : wait_irq

    // compare sampled symbols from the first line change onward
    task run_line(input int p);
        int j0, n;
        j0 = 0;
        while (j0 < exp_q.size() && exp_q[j0] === rftx_pkg::IDLE_LEVEL) j0++;
        n = 0;
        while (cnt < exp_q.size() - j0 && n < (exp_q.size() + 4) * p) begin
            @(posedge clk);
            n++;
        end
        chk(cnt >= exp_q.size() - j0, 1);
        for (int k = 0; k < exp_q.size() - j0; k++) chk(sym[k], exp_q[j0 + k]);
        arm <= 1'b0;
    endtask : run_line

    initial begin
        #200000;
        fails++;
        end_sim();
    end

    initial begin
        logic [7:0] ofs [7];
        ofs = '{rftx_pkg::OFS_CTRL, rftx_pkg::OFS_BAUD, rftx_pkg::OFS_TX_DATA,
            rftx_pkg::OFS_STATE, rftx_pkg::OFS_IRQ_STATUS, rftx_pkg::OFS_IRQ_CLEAR,
            rftx_pkg::OFS_IRQ_ENABLE};
        {rst, psel, penable, pwrite, arm, clk_run} = 6'h20;
        paddr = 8'h00;
        pwdata = 32'h0;
        per = 16;
        fails = 0;
        checked = 0;
        seed = 16'h5046;
        do_reset();
        // reset values, mapped and unmapped reads
        for (i = 0; i < 7; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            chk({err, rd}, 33'h0);
        end
        apb(1'b0, 8'h1C, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        seed = lfsr_next(seed);
        apb(1'b1, rftx_pkg::OFS_BAUD, {26'h0, seed[5:0]});
        apb(1'b0, rftx_pkg::OFS_BAUD, 32'h0);
        chk(rd, {26'h0, seed[5:0]});
        apb(1'b1, rftx_pkg::OFS_BAUD, 32'h0);
        // preamble: fill while stopped, overflow, then send
        apb(1'b1, rftx_pkg::OFS_CTRL, 32'h14); // encoder on, space coding, idle
        for (i = 0; i < 4; i++) apb(1'b1, rftx_pkg::OFS_TX_DATA, 32'h0);
        apb(1'b1, rftx_pkg::OFS_TX_DATA, 32'h0); // fifth byte overflows
        apb(1'b0, rftx_pkg::OFS_STATE, 32'h0);
        chk(rd, 32'h0C);
        apb(1'b0, rftx_pkg::OFS_IRQ_STATUS, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, rftx_pkg::OFS_IRQ_ENABLE, 32'h1);
        apb(1'b1, rftx_pkg::OFS_CTRL, 32'h17); // receive also on: must stay quiet
        repeat (50) @(posedge clk);
        apb(1'b0, rftx_pkg::OFS_STATE, 32'h0);
        chk({oe, rd}, 33'h0C);
        start_cap(sym_period(0, 0));
        for (i = 0; i < 4; i++) enc_byte(8'h00, 1'b1, rftx_pkg::CODE_NRZ_SPACE);
        apb(1'b1, rftx_pkg::OFS_CTRL, 32'h16);
        chk(oe, 1);
        wait_irq();
        apb(1'b0, rftx_pkg::OFS_STATE, 32'h0);
        chk(rd & 32'h5F, 32'h50);
        run_line(sym_period(0, 0));
        repeat (100) @(posedge clk);
        chk(txd, exp_q[$]);
        apb(1'b0, rftx_pkg::OFS_IRQ_STATUS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, rftx_pkg::OFS_IRQ_ENABLE, 32'h0);
        chk(irq, 0);
        apb(1'b1, rftx_pkg::OFS_IRQ_ENABLE, 32'h3);
        chk(irq, 1);
        apb(1'b1, rftx_pkg::OFS_IRQ_CLEAR, 32'h3);
        apb(1'b0, rftx_pkg::OFS_IRQ_STATUS, 32'h0);
        chk({irq, rd}, 33'h0);
        // raw byte, encoder switched on while it is still shifting
        do_reset();
        apb(1'b1, rftx_pkg::OFS_IRQ_ENABLE, 32'h1);
        apb(1'b1, rftx_pkg::OFS_CTRL, 32'h02);
        seed = lfsr_next(seed);
        b = seed[7:0];
        enc_byte(b, 1'b0, 3'h0);
        enc_byte(8'h00, 1'b1, rftx_pkg::CODE_NRZ_SPACE);
        start_cap(16);
        apb(1'b1, rftx_pkg::OFS_TX_DATA, {24'h0, b});
        wait_irq();
        apb(1'b1, rftx_pkg::OFS_CTRL, 32'h16);
        apb(1'b1, rftx_pkg::OFS_TX_DATA, 32'h0);
        run_line(16);
        // miller, product 12, bit clock toggling but not selected
        do_reset();
        apb(1'b1, rftx_pkg::OFS_BAUD, 32'h12);
        clk_run <= 1'b1;
        start_cap(sym_period(1, 2));
        apb(1'b1, rftx_pkg::OFS_CTRL, 32'h3E);
        for (i = 0; i < 2; i++) begin
            seed = lfsr_next(seed);
            enc_byte(seed[7:0], 1'b1, rftx_pkg::CODE_MILLER);
            apb(1'b1, rftx_pkg::OFS_TX_DATA, {24'h0, seed[7:0]});
        end
        run_line(sym_period(1, 2));
        // external bit clock selected: one raw symbol per rising pin edge
        do_reset();
        apb(1'b1, rftx_pkg::OFS_CTRL, 32'h42);
        seed = lfsr_next(seed);
        enc_byte(seed[7:0], 1'b0, 3'h0);
        start_cap(4);
        apb(1'b1, rftx_pkg::OFS_TX_DATA, {24'h0, seed[7:0]});
        run_line(4);
        clk_run <= 1'b0;
        end_sim();
    end
endmodule : radio_tx_encoder_fifo_tb
